// ---- hw/sfs_sequencer.v ----
// soft-start, pre-bias, overcurrent hiccup and gate sequencing core
`timescale 1ns/100ps
`default_nettype none
`include "sfs_map.vh"

module sfs_sequencer #(
  parameter DAC_W = `SFS_DAC_W,
  parameter PWM_W = `SFS_PWM_W
) (
  input  wire               clk,
  input  wire               rst_b,
  input  wire               enable_pin,
  input  wire               rail_above_min,
  input  wire               lockout_sense_pin,
  input  wire [1:0]         ramp_sel,
  input  wire [DAC_W-1:0]   ramp_ref_code,
  input  wire [DAC_W-1:0]   feedback_code,
  input  wire [PWM_W-1:0]   duty_code,
  input  wire               high_oc,
  input  wire               low_oc,
  input  wire               switch_node_low,
  input  wire               high_gate_sense,
  input  wire               low_gate_sense,
  input  wire [3:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [7:0]         reg_rdata,
  output reg                high_gate_drive,
  output reg                low_gate_drive,
  output reg                rail_regulator_on,
  output reg                hyst_source_on,
  output reg  [DAC_W-1:0]   ss_dac_code,
  output reg                ss_active,
  output reg                fault_active
);

  // one-hot sequencer states
  localparam ST_OFF    = 4'b0001;
  localparam ST_RAMP   = 4'b0010;
  localparam ST_RUN    = 4'b0100;
  localparam ST_HICCUP = 4'b1000;

  // pin inputs cross into the clock domain through three stages
  wire en_q_r;
  wire rail_q_r;
  wire lock_q_r;
  wire hoc_q_r;
  wire loc_q_r;

  sfs_pin_sync u_en_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (enable_pin),
    .q_r   (en_q_r)
  );

  sfs_pin_sync u_rail_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (rail_above_min),
    .q_r   (rail_q_r)
  );

  sfs_pin_sync u_lock_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (lockout_sense_pin),
    .q_r   (lock_q_r)
  );

  sfs_pin_sync u_hoc_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (high_oc),
    .q_r   (hoc_q_r)
  );

  sfs_pin_sync u_loc_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (low_oc),
    .q_r   (loc_q_r)
  );

  // software override register: bit0 forces the sequencer off, the rail regulator still follows the enable pin
  reg soft_off_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      soft_off_r <= 1'b0;
    else if (reg_wr && reg_addr == `SFS_REG_CTRL)
      soft_off_r <= reg_wdata[0];
  end

  wire enabled = en_q_r & ~soft_off_r;
  wire start_ok = rail_q_r & lock_q_r;

  // ramp length from select pin
  reg [DAC_W-1:0] ramp_len;
  reg [DAC_W+2:0] hiccup_len;
  always @* begin
    case (ramp_sel)
      `SFS_SEL_GND: begin
        ramp_len   = `SFS_RAMP_GND;
        hiccup_len = `SFS_HICCUP_GND;
      end
      `SFS_SEL_FLOAT: begin
        ramp_len   = `SFS_RAMP_FLOAT;
        hiccup_len = `SFS_HICCUP_FLOAT;
      end
      `SFS_SEL_RAIL: begin
        ramp_len   = `SFS_RAMP_RAIL;
        hiccup_len = `SFS_HICCUP_RAIL;
      end
      default: begin
        ramp_len   = `SFS_RAMP_FLOAT;
        hiccup_len = `SFS_HICCUP_FLOAT;
      end
    endcase
  end

  // pwm cycle timebase
  reg [PWM_W-1:0] phase_r;
  wire cycle_end = (phase_r == {PWM_W{1'b1}});

  reg [3:0]       state_r;
  reg [3:0]       state_nxt;
  reg [DAC_W-1:0] ramp_cnt_r;
  reg [DAC_W+2:0] off_cnt_r;
  reg [2:0]       fault_cnt_r;
  reg [5:0]       widen_r;
  reg             rect_on_r;
  reg             cyc_oc_r;
  reg             hs_cut_r;

  // dac code is the ramp count itself: one code step per clock, up to ramp_len
  wire [DAC_W-1:0] dac_now = ramp_cnt_r;
  wire ss_done = (dac_now > ramp_ref_code) || (ramp_cnt_r == ramp_len);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:    if (enabled && start_ok) state_nxt = ST_RAMP;
      ST_RAMP:   if (fault_cnt_r == `SFS_FAULT_LIMIT) state_nxt = ST_HICCUP;
                 else if (ss_done) state_nxt = ST_RUN;
      ST_RUN:    if (fault_cnt_r == `SFS_FAULT_LIMIT) state_nxt = ST_HICCUP;
      ST_HICCUP: if (off_cnt_r == hiccup_len) state_nxt = ST_OFF;
      default:   state_nxt = ST_OFF;
    endcase
    // losing enable or a qualifier always returns to off
    if (!enabled || !start_ok)
      state_nxt = ST_OFF;
  end

  // timebase and fault counter only run while switching
  wire switching = (state_r == ST_RAMP) || (state_r == ST_RUN);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= ST_OFF;
      phase_r     <= {PWM_W{1'b0}};
      ramp_cnt_r  <= {DAC_W{1'b0}};
      off_cnt_r   <= {(DAC_W+3){1'b0}};
      fault_cnt_r <= 3'h0;
      widen_r     <= 6'h0;
      rect_on_r   <= 1'b0;
      cyc_oc_r    <= 1'b0;
      hs_cut_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= switching ? phase_r + 1'b1 : {PWM_W{1'b0}};
      if (state_r == ST_RAMP && ramp_cnt_r != ramp_len)
        ramp_cnt_r <= ramp_cnt_r + 1'b1;
      else if (state_r == ST_OFF || state_r == ST_HICCUP)
        ramp_cnt_r <= {DAC_W{1'b0}};
      if (state_r == ST_HICCUP)
        off_cnt_r <= off_cnt_r + 1'b1;
      else
        off_cnt_r <= {(DAC_W+3){1'b0}};
      // per-cycle overcurrent bookkeeping
      // counter holds at seven and at zero
      if (!switching) begin
        fault_cnt_r <= 3'h0;
        cyc_oc_r    <= 1'b0;
        hs_cut_r    <= 1'b0;
      end else if (cycle_end) begin
        if (cyc_oc_r || hoc_q_r || loc_q_r) begin
          if (fault_cnt_r != `SFS_FAULT_LIMIT)
            fault_cnt_r <= fault_cnt_r + 3'h1;
        end else if (fault_cnt_r != 3'h0) begin
          fault_cnt_r <= fault_cnt_r - 3'h1;
        end
        cyc_oc_r <= 1'b0;
        hs_cut_r <= 1'b0;
      end else begin
        if (hoc_q_r || loc_q_r)
          cyc_oc_r <= 1'b1;
        if (hoc_q_r && high_gate_drive)
          hs_cut_r <= 1'b1;
      end
      // pre-bias: rectification waits until ramp passes feedback or the run state begins
      if (!switching) begin
        rect_on_r <= 1'b0;
        widen_r   <= 6'h0;
      end else begin
        if (dac_now > feedback_code || state_r == ST_RUN)
          rect_on_r <= 1'b1;
        // one step per clock, full window after 32 clocks
        if (rect_on_r && widen_r != `SFS_LS_WIDEN_CYCLES)
          widen_r <= widen_r + 6'h1;
      end
    end
  end

  // low-side window: full (1-D) scaled by widen/32
  wire [PWM_W-1:0] comp_len = ~duty_code;
  wire [PWM_W+5:0] ls_prod  = comp_len * widen_r;
  wire [PWM_W-1:0] ls_len   = ls_prod[PWM_W+4:5];
  wire high_want = switching && !hs_cut_r && !hoc_q_r && (phase_r < duty_code);
  wire low_want  = switching && rect_on_r && (phase_r >= duty_code) &&
                   ((phase_r - duty_code) < ls_len);

  // adaptive dead time: each gate waits for the other gate, the low side also for the switch node
  wire hg_on_q;
  wire lg_on_q;
  wire sw_low_q;

  sfs_pin_sync u_hg_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (high_gate_sense),
    .q_r   (hg_on_q)
  );

  sfs_pin_sync u_lg_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (low_gate_sense),
    .q_r   (lg_on_q)
  );

  sfs_pin_sync u_sw_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (switch_node_low),
    .q_r   (sw_low_q)
  );

  wire hg_off = ~hg_on_q;
  wire lg_off = ~lg_on_q;
  wire sw_low = sw_low_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_gate_drive   <= 1'b0;
      low_gate_drive    <= 1'b0;
      rail_regulator_on <= 1'b0;
      hyst_source_on    <= 1'b0;
      ss_dac_code       <= {DAC_W{1'b0}};
      ss_active         <= 1'b0;
      fault_active      <= 1'b0;
    end else begin
      // gates drop on the entry edge of the hiccup as well
      if (state_nxt == ST_HICCUP || state_r == ST_HICCUP) begin
        high_gate_drive <= 1'b0;
        low_gate_drive  <= 1'b0;
      end else begin
        high_gate_drive <= high_want && !low_gate_drive && lg_off;
        low_gate_drive  <= low_want && !high_gate_drive && hg_off && sw_low;
      end
      // ss and fault outputs follow the state one clock late, regulator and hysteresis follow the synced pins
      rail_regulator_on <= en_q_r;
      hyst_source_on    <= lock_q_r;
      ss_dac_code       <= (state_r == ST_RUN) ? ramp_ref_code : dac_now;
      ss_active         <= (state_r == ST_RAMP);
      fault_active      <= (state_r == ST_HICCUP);
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `SFS_REG_CTRL:     reg_rdata <= {7'h00, soft_off_r};
        `SFS_REG_STATUS:   reg_rdata <= {state_r, rect_on_r, lock_q_r, rail_q_r, en_q_r};
        `SFS_REG_FAULTCNT: reg_rdata <= {5'h00, fault_cnt_r};
        // unmapped addresses read as zero
        default:           reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end

endmodule

// three-stage pin sampler, output moves once stages two and three agree
module sfs_pin_sync (
  input  wire clk,
  input  wire rst_b,
  input  wire pin,
  output reg  q_r
);

  reg [2:0] s_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= 3'h0;
      q_r <= 1'b0;
    end else begin
      s_r <= {s_r[1:0], pin};
      // a one-cycle glitch never reaches both compared stages
      if (s_r[1] == s_r[2])
        q_r <= s_r[2];
    end
  end

endmodule
`default_nettype wire

// ---- hw/sfs_map.vh ----
// constants for the soft-start and fault sequencer
`ifndef SFS_MAP_VH
`define SFS_MAP_VH
`define SFS_RAMP_GND          12'h800
`define SFS_RAMP_FLOAT        12'h400
`define SFS_RAMP_RAIL         12'h200
`define SFS_SEL_GND           2'h0
`define SFS_SEL_FLOAT         2'h1
`define SFS_SEL_RAIL          2'h2
`define SFS_FAULT_LIMIT       3'h7
`define SFS_HICCUP_MULT       7
`define SFS_HICCUP_GND        15'h3800
`define SFS_HICCUP_FLOAT      15'h1C00
`define SFS_HICCUP_RAIL       15'h0E00
`define SFS_LS_WIDEN_CYCLES   6'h20
`define SFS_DAC_W             12
`define SFS_PWM_W             8
`define SFS_DEAD_MAX          4'hF
`define SFS_REF_MV            591
`define SFS_RAMP_MV           1000
`define SFS_RAIL_MV           4300
`define SFS_HYST_NA           5200
`define SFS_LOCKOUT_MV        1260
`define SFS_REG_WR_ADDR       4'h0
`define SFS_REG_CTRL          4'h0
`define SFS_REG_STATUS        4'h1
`define SFS_REG_FAULTCNT      4'h2
`endif

// ---- verif/sfs_monitor.sv ----
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module sfs_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        enable_pin,
  input wire logic        rail_above_min,
  input wire logic        lockout_sense_pin,
  input wire logic        high_oc,
  input wire logic [11:0] ramp_ref_code,
  input wire logic [11:0] feedback_code,
  input wire logic        high_gate_drive,
  input wire logic        low_gate_drive,
  input wire logic        rail_regulator_on,
  input wire logic        hyst_source_on,
  input wire logic [11:0] ss_dac_code,
  input wire logic        ss_active,
  input wire logic        fault_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_gates_apart: assert property (!(high_gate_drive && low_gate_drive))
    else $error("gates overlap");
  chk_fault_off: assert property (fault_active |-> !high_gate_drive && !low_gate_drive)
    else $error("gate on in fault");
  chk_ramp_step: assert property (ss_active && $past(ss_active)
    |-> ss_dac_code == $past(ss_dac_code) + 12'h001) else $error("ramp step");
  chk_ref_end: assert property (ss_active |-> ss_dac_code <= ramp_ref_code + 13'h0002)
    else $error("ramp past reference");
  chk_rect_wait: assert property (ss_active && ss_dac_code + 13'h0004 < feedback_code
    |-> !low_gate_drive) else $error("early rectification");
  chk_oc_cut: assert property (high_oc [*8] |-> ##[0:2] !high_gate_drive)
    else $error("high pulse not cut");
  chk_rail_gate: assert property ((!rail_above_min) [*6] |=> !$rose(ss_active))
    else $error("start without rail");
  chk_hyst_on: assert property ((lockout_sense_pin && enable_pin) [*8] |-> hyst_source_on)
    else $error("hysteresis off");
  chk_shut_down: assert property ((!enable_pin) [*8] |-> !rail_regulator_on && !ss_active)
    else $error("running while disabled");
  chk_hiccup_hold: assert property ($rose(fault_active)
    |-> (fault_active && !ss_active) [*8]) else $error("hiccup too short");
endmodule
`default_nettype wire

// ---- verif/sfs_gate_model.sv ----
// external gate drivers and switch node
`timescale 1ns/100ps
`default_nettype none
module sfs_gate_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic high_gate_drive,
  input  wire logic low_gate_drive,
  output var  logic high_gate_sense,
  output var  logic low_gate_sense,
  output var  logic switch_node_low
);
  logic [2:0] hs_q;
  logic [2:0] ls_q;
  // slow gates settle three cycles late
  always @(posedge clk) begin
    hs_q <= {hs_q[1:0], high_gate_drive};
    ls_q <= {ls_q[1:0], low_gate_drive};
  end
  assign high_gate_sense = slow ? hs_q[2] : hs_q[0];
  assign low_gate_sense  = slow ? ls_q[2] : ls_q[0];
  assign switch_node_low = !high_gate_sense;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the soft-start and fault sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk, rst_b, enable_pin, rail_above_min, lockout_sense_pin, slow;
  logic       high_oc, low_oc, reg_wr, reg_rd, switch_node_low, high_gate_sense;
  logic       low_gate_sense, high_gate_drive, low_gate_drive, rail_regulator_on;
  logic       hyst_source_on, ss_active, fault_active;
  logic [1:0] ramp_sel;
  logic [3:0] reg_addr;
  logic [7:0] duty_code, reg_wdata, reg_rdata, got;
  logic [11:0] ramp_ref_code, feedback_code, ss_dac_code;
  int         n_fail, n_checks, n, lens[4];
  sfs_sequencer DUT (.clk, .rst_b, .enable_pin, .rail_above_min, .lockout_sense_pin,
    .ramp_sel, .ramp_ref_code, .feedback_code, .duty_code, .high_oc, .low_oc,
    .switch_node_low, .high_gate_sense, .low_gate_sense, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .high_gate_drive, .low_gate_drive, .rail_regulator_on,
    .hyst_source_on, .ss_dac_code, .ss_active, .fault_active);
  sfs_gate_model gates (.clk, .slow, .high_gate_drive, .low_gate_drive, .high_gate_sense,
    .low_gate_sense, .switch_node_low);
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    got = reg_rdata;
    @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // cycles until the chosen flag reaches v, left in n
  task wt(input bit f, input logic v, input int lim);
    n = 0;
    while ((f ? fault_active : ss_active) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("wait", n < lim, 1);
  endtask
  task restart;
    enable_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk("reg_off", rail_regulator_on, 0);
    enable_pin <= 1'b1;
    wt(0, 1, 60);
  endtask
  task end_sim;
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hB0D7));
    lens = '{2048, 1024, 512, 1024};
    {rst_b, enable_pin, rail_above_min, lockout_sense_pin, high_oc, low_oc} = 0;
    {slow, reg_wr, reg_rd, ramp_sel, reg_addr, reg_wdata, duty_code, feedback_code} = 0;
    ramp_ref_code = 12'hFFF;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(4'h2);
    chk("faultcnt", got, 0);
    rd(4'hF);
    chk("unmapped", got, 0);
    enable_pin <= 1'b1;
    lockout_sense_pin <= 1'b1;
    repeat (50) @(posedge clk);
    chk("no_rail", ss_active, 0);
    chk("hyst", hyst_source_on, 1);
    lockout_sense_pin <= 1'b0;
    rail_above_min <= 1'b1;
    repeat (50) @(posedge clk);
    chk("no_lock", ss_active, 0);
    lockout_sense_pin <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      ramp_sel <= s[1:0];
      slow <= s[0];
      duty_code <= 8'($urandom_range(40, 200));
      feedback_code <= 12'($urandom_range(0, 300));
      restart;
      wt(0, 0, 3000);
      chk("ramp_len", n >= lens[s] - 2 && n <= lens[s] + 2, 1);
      n = 0;
      repeat (256) @(posedge clk) n += low_gate_drive;
      chk("ls_on", n > 0 && n < 256, 1);
    end
    ramp_ref_code <= 12'($urandom_range(100, 400));
    restart;
    wt(0, 0, 3000);
    chk("ref_end", n + 1 >= ramp_ref_code && n <= ramp_ref_code + 3, 1);
    ramp_sel <= 2'h2;
    restart;
    wt(0, 0, 3000);
    high_oc <= 1'b1;
    repeat (768) @(posedge clk);
    high_oc <= 1'b0;
    rd(4'h2);
    chk("cnt_up", got >= 3 && got <= 4, 1);
    repeat (1280) @(posedge clk);
    rd(4'h2);
    chk("cnt_down", got, 0);
    high_oc <= 1'b1;
    wt(1, 1, 2200);
    chk("trip", n > 1500, 1);
    wt(1, 0, 4000);
    chk("off_time", n >= 3583 && n <= 3587, 1);
    high_oc <= 1'b0;
    low_oc <= 1'b1;
    wt(0, 1, 10);
    wt(1, 1, 2200);
    low_oc <= 1'b0;
    wt(1, 0, 4000);
    wt(0, 1, 10);
    rd(4'h2);
    chk("cnt_clr", got, 0);
    wt(0, 0, 3000);
    wr(4'h0, 8'h01);
    repeat (4) @(posedge clk);
    chk("soft_off", {high_gate_drive, low_gate_drive, ss_active}, 0);
    rd(4'h1);
    chk("status", got, 8'h17);
    wr(4'h3, 8'h01);
    rd(4'h0);
    chk("ctrl", got, 1);
    wr(4'h0, 8'h00);
    wt(0, 1, 30);
    end_sim;
  end
endmodule
bind sfs_sequencer sfs_monitor mon (.clk, .rst_b, .enable_pin, .rail_above_min,
  .lockout_sense_pin, .high_oc, .ramp_ref_code, .feedback_code, .high_gate_drive,
  .low_gate_drive, .rail_regulator_on, .hyst_source_on, .ss_dac_code, .ss_active,
  .fault_active);
`default_nettype wire
